// File: include/qfsc_regs.svh
`ifndef QFSC_REGS_SVH
`define QFSC_REGS_SVH

// ----------------------------------------------------------------
// Clock and timing.
// ----------------------------------------------------------------
`define QFSC_CLK_HZ          25000000
`define QFSC_CLK_MHZ         25
`define QFSC_BLANK_MIN_NS    4160
`define QFSC_BLANK_MAX_NS    16000
`define QFSC_DELAY_NS        197
`define QFSC_FORCE_NS        2700
`define QFSC_STARTER_NS      23000
`define QFSC_FMAX_HZ         240000
`define QFSC_RESTART_S       2

// Least times round up to whole cycles.
`define QFSC_CEIL_CYC(ns)    ((((ns) * `QFSC_CLK_MHZ) + 999) / 1000)
`define QFSC_BLANK_MIN_CYC   `QFSC_CEIL_CYC(`QFSC_BLANK_MIN_NS)
`define QFSC_BLANK_MAX_CYC   `QFSC_CEIL_CYC(`QFSC_BLANK_MAX_NS)
`define QFSC_DELAY_CYC       `QFSC_CEIL_CYC(`QFSC_DELAY_NS)
`define QFSC_FORCE_CYC       `QFSC_CEIL_CYC(`QFSC_FORCE_NS)
`define QFSC_STARTER_CYC     `QFSC_CEIL_CYC(`QFSC_STARTER_NS)
`define QFSC_MIN_PERIOD_CYC  ((`QFSC_CLK_HZ + `QFSC_FMAX_HZ - 1) / `QFSC_FMAX_HZ)
`define QFSC_RESTART_CYC     (`QFSC_RESTART_S * `QFSC_CLK_HZ)

// ----------------------------------------------------------------
// Feedback code span and synchroniser bit positions.
// ----------------------------------------------------------------
`define QFSC_FBK_CODE_MAX    15
`define QFSC_S_ARM           0
`define QFSC_S_TRIG          1
`define QFSC_S_BURST_LOW     2
`define QFSC_S_BURST_HIGH    3
`define QFSC_S_VL_OFF        4
`define QFSC_S_VL_ON         5
`define QFSC_S_FOLD          6
`define QFSC_S_REG_ON        7
`define QFSC_S_STARTUP       8
`define QFSC_S_TURNOFF       9
`define QFSC_S_LOCKOUT       10
`define QFSC_S_DSUP_GOOD     11
`define QFSC_S_DSUP_LOW      12
`define QFSC_S_DSUP_OVER     13
`define QFSC_S_OTEMP         14
`define QFSC_S_RECT          15
`define QFSC_S_ILIM          16
`define QFSC_S_W             17

`endif

// File: include/qfsc_pkg.sv
package qfsc_pkg;

  typedef enum logic [3:0] {
    ST_CHARGE,
    ST_SEQ,
    ST_DSUP_WAIT,
    ST_ON,
    ST_OFF,
    ST_DELAY,
    ST_BURST,
    ST_FAULT
  } qfsc_state_t;

endpackage

// File: hw/qfsc_sync.sv
`timescale 1ns/1ps
module qfsc_sync #(
  parameter int N = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] d,
  output logic      [N-1:0] q
);

  // ----------------------------------------------------------------
  // Two flip-flops per comparator bit.
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      logic meta_r;
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          meta_r <= 1'b0;
          q[i]   <= 1'b0;
        end else begin
          meta_r <= d[i];
          q[i]   <= meta_r;
        end
      end
    end
  endgenerate

endmodule

// File: hw/qfsc_timer.sv
`timescale 1ns/1ps
module qfsc_timer #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clr,
  output logic      [W-1:0] cnt_r
);

  // ----------------------------------------------------------------
  // Saturating up counter, cleared to zero by clr.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (clr) begin
      cnt_r <= '0;
    end else if (cnt_r != {W{1'b1}}) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

endmodule

// File: hw/qfsc_core.sv
// What this block does
// - Armed trigger fires on falling demag crossing.
// - Arming needs prior rise above arm level.
// - Triggers ignored during blanking after turn-on.
// - Switching period never below 240 kHz limit.
// - Blanking shrinks linearly with rising feedback.
// - Valid late trigger turns on after delay.
// - Without valley lock, only first trigger after blanking counts.
// - Forced turn-on after timeout past blanking.
// - Starter runs cycles until arming succeeds.
// - Valley lock holds skipped valley count.
// - Valley lock off below 1.3, on 1.43.
// - Feedback below burst minus hysteresis stops switching.
// - Burst pause ends at burst threshold.
// - Charge slow below foldback, then full.
// - Driver regulator enabled at regulator level.
// - Ordered start-up switch sequence at threshold.
// - No switching before driver supply good.
// - Gate blocked while driver supply too high.
// - Low driver supply stops switching.
// - Supply below turn-off reverts to charging.
// - Lockout falling edge resets all state except the input synchronisers and lockout edge register.
// - Faults hold off for restart interval.
// - Blanking 4.16 us high, 16 us low.
// - Turn-on delay about 197 ns.
`timescale 1ns/1ps
`include "qfsc_regs.svh"
module qfsc_core #(
  parameter int unsigned RESTART_CYC = `QFSC_RESTART_CYC
) (
  input  wire logic       CLK,
  input  wire logic       RST_B,
  input  wire logic       DEMAG_ABOVE_ARM,
  input  wire logic       DEMAG_BELOW_TRIG,
  input  wire logic       FEEDBACK_BELOW_BURST_HYST,
  input  wire logic       FEEDBACK_ABOVE_BURST,
  input  wire logic       FEEDBACK_BELOW_VL_OFF,
  input  wire logic       FEEDBACK_ABOVE_VL_ON,
  input  wire logic [3:0] FEEDBACK_CODE,
  input  wire logic       SUPPLY_ABOVE_FOLDBACK,
  input  wire logic       SUPPLY_ABOVE_REG_ON,
  input  wire logic       SUPPLY_ABOVE_STARTUP,
  input  wire logic       SUPPLY_BELOW_TURNOFF,
  input  wire logic       SUPPLY_ABOVE_LOCKOUT,
  input  wire logic       DRIVER_SUPPLY_GOOD,
  input  wire logic       DRIVER_SUPPLY_LOW,
  input  wire logic       DRIVER_SUPPLY_OVER,
  input  wire logic       OVER_TEMP,
  input  wire logic       RECT_SHORT_FAULT,
  input  wire logic       CURRENT_LIMIT,
  output logic            GATE_ON,
  output logic            CHARGE_EN,
  output logic            CHARGE_FULL_RATE,
  output logic            HV_GATE_PATH_SWITCH,
  output logic            GATE_PULLDOWN_SWITCH,
  output logic            HV_TO_INOVP_SWITCH,
  output logic            LOWSIDE_SENSE_SWITCH,
  output logic            DRIVER_SUPPLY_REG_EN,
  output logic            LOW_QUIESCENT,
  output logic            VALLEY_LOCK_EN,
  output logic            TRIGGER_ARMED,
  output logic            FAULT_RESTART_WAIT
);
  import qfsc_pkg::*;

  localparam logic [15:0] BMIN   = 16'(`QFSC_BLANK_MIN_CYC);
  localparam logic [15:0] BMAX   = 16'(`QFSC_BLANK_MAX_CYC);
  localparam logic [15:0] FORCE  = 16'(`QFSC_FORCE_CYC);
  localparam logic [15:0] START  = 16'(`QFSC_STARTER_CYC);
  localparam logic [15:0] CMAX   = 16'(`QFSC_FBK_CODE_MAX);
  localparam logic [31:0] DLYM1  = 32'(`QFSC_DELAY_CYC - 1);
  localparam logic [31:0] RSTM1  = RESTART_CYC - 32'd1;
  localparam int          DLY    = `QFSC_DELAY_CYC;
  localparam int          MINP   = `QFSC_MIN_PERIOD_CYC;

  // ----------------------------------------------------------------
  // Comparator synchronisers and internal reset.
  // ----------------------------------------------------------------
  logic [`QFSC_S_W-1:0] s;
  logic                 lock_d_r;
  logic                 lockout_fall;
  logic                 rst_n_i;

  qfsc_sync #(.N(`QFSC_S_W)) u_sync (
    .clk   (CLK),
    .rst_n (RST_B),
    .d     ({CURRENT_LIMIT, RECT_SHORT_FAULT, OVER_TEMP, DRIVER_SUPPLY_OVER,
             DRIVER_SUPPLY_LOW, DRIVER_SUPPLY_GOOD, SUPPLY_ABOVE_LOCKOUT,
             SUPPLY_BELOW_TURNOFF, SUPPLY_ABOVE_STARTUP, SUPPLY_ABOVE_REG_ON,
             SUPPLY_ABOVE_FOLDBACK, FEEDBACK_ABOVE_VL_ON, FEEDBACK_BELOW_VL_OFF,
             FEEDBACK_ABOVE_BURST, FEEDBACK_BELOW_BURST_HYST, DEMAG_BELOW_TRIG,
             DEMAG_ABOVE_ARM}),
    .q     (s)
  );

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      lock_d_r <= 1'b0;
    end else begin
      lock_d_r <= s[`QFSC_S_LOCKOUT];
    end
  end

  assign lockout_fall = lock_d_r & ~s[`QFSC_S_LOCKOUT];
  assign rst_n_i      = RST_B & ~lockout_fall;

  // ----------------------------------------------------------------
  // Timers and blanking length.
  // ----------------------------------------------------------------
  qfsc_state_t state_r;
  qfsc_state_t state_nxt;
  logic [15:0] per_cnt;
  logic [31:0] st_tmr;
  logic [15:0] blank_len;
  logic [15:0] force_at;

  qfsc_timer #(.W(16)) u_per (
    .clk   (CLK),
    .rst_n (rst_n_i),
    .clr   (state_nxt == ST_ON && state_r != ST_ON),
    .cnt_r (per_cnt)
  );

  qfsc_timer #(.W(32)) u_st (
    .clk   (CLK),
    .rst_n (rst_n_i),
    .clr   (state_nxt != state_r),
    .cnt_r (st_tmr)
  );

  assign blank_len = BMAX - 16'(((BMAX - BMIN) * {12'h000, FEEDBACK_CODE}) / CMAX);

  // ----------------------------------------------------------------
  // Trigger arming, valley counting and valley lock.
  // ----------------------------------------------------------------
  logic       arm_d_r;
  logic       trig_d_r;
  logic       armed_r;
  logic       locked_r;
  logic       vl_en_r;
  logic [3:0] vcnt_r;
  logic [3:0] lock_vc_r;
  logic       trig_fall;
  logic       fire_trig;
  logic       fire;
  logic       off_st;
  logic       run_st;
  logic       prio;

  assign off_st    = (state_r == ST_OFF);
  assign run_st    = (state_r == ST_ON) | off_st | (state_r == ST_DELAY);
  assign trig_fall = s[`QFSC_S_TRIG] & ~trig_d_r;
  assign force_at  = blank_len + (locked_r ? FORCE : START);
  assign fire_trig = off_st & trig_fall & armed_r & (per_cnt >= blank_len) &
                     (~vl_en_r | (vcnt_r >= lock_vc_r));
  assign fire      = fire_trig | (off_st & (per_cnt >= force_at));
  assign prio      = s[`QFSC_S_TURNOFF] | s[`QFSC_S_OTEMP] | s[`QFSC_S_RECT] |
                     s[`QFSC_S_DSUP_LOW];

  // The sense rests below the trigger level, so the delayed copy starts high and reset makes no false crossing.
  always_ff @(posedge CLK) begin
    if (!rst_n_i) begin
      arm_d_r  <= 1'b0;
      trig_d_r <= 1'b1;
    end else begin
      arm_d_r  <= s[`QFSC_S_ARM];
      trig_d_r <= s[`QFSC_S_TRIG];
    end
  end

  always_ff @(posedge CLK) begin
    if (!rst_n_i) begin
      armed_r  <= 1'b0;
      locked_r <= 1'b0;
    end else if (fire) begin
      armed_r  <= 1'b0;
    end else if (s[`QFSC_S_ARM] & ~arm_d_r) begin
      armed_r  <= 1'b1;
      locked_r <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!rst_n_i) begin
      vl_en_r <= 1'b0;
    end else if (s[`QFSC_S_VL_OFF]) begin
      vl_en_r <= 1'b0;
    end else if (s[`QFSC_S_VL_ON]) begin
      vl_en_r <= 1'b1;
    end
  end

  // Valleys seen since turn-on; the locked count lock_vc_r is frozen while the lock holds.
  always_ff @(posedge CLK) begin
    if (!rst_n_i) begin
      vcnt_r    <= 4'h0;
      lock_vc_r <= 4'h0;
    end else begin
      if (state_r == ST_ON) begin
        vcnt_r <= 4'h0;
      end else if (off_st && trig_fall && vcnt_r != 4'hF) begin
        vcnt_r <= vcnt_r + 4'h1;
      end
      if (fire_trig && !vl_en_r) begin
        lock_vc_r <= vcnt_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control state machine.
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_CHARGE: begin
        if (s[`QFSC_S_STARTUP] && !s[`QFSC_S_TURNOFF]) begin
          state_nxt = ST_SEQ;
        end
      end
      ST_SEQ: begin
        if (st_tmr >= 32'd4) begin
          state_nxt = ST_DSUP_WAIT;
        end
      end
      ST_DSUP_WAIT: begin
        if (s[`QFSC_S_DSUP_GOOD]) begin
          state_nxt = ST_OFF;
        end
      end
      ST_ON: begin
        // A blocked pulse still ends the on-time, so releasing the block never opens a short period.
        if (s[`QFSC_S_ILIM] || s[`QFSC_S_DSUP_OVER]) begin
          state_nxt = ST_OFF;
        end
      end
      ST_OFF: begin
        if (fire) begin
          state_nxt = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (st_tmr >= DLYM1) begin
          state_nxt = ST_ON;
        end
      end
      ST_BURST: begin
        if (s[`QFSC_S_BURST_HIGH]) begin
          state_nxt = ST_OFF;
        end
      end
      ST_FAULT: begin
        if (st_tmr >= RSTM1) begin
          state_nxt = ST_DSUP_WAIT;
        end
      end
      default: state_nxt = ST_CHARGE;
    endcase
    if (state_r != ST_CHARGE && state_r != ST_SEQ) begin
      if (s[`QFSC_S_TURNOFF]) begin
        state_nxt = ST_CHARGE;
      end else if (state_r != ST_FAULT && (s[`QFSC_S_OTEMP] || s[`QFSC_S_RECT])) begin
        state_nxt = ST_FAULT;
      end else if (state_r != ST_FAULT && state_r != ST_DSUP_WAIT && s[`QFSC_S_DSUP_LOW]) begin
        state_nxt = ST_DSUP_WAIT;
      end else if (run_st && s[`QFSC_S_BURST_LOW]) begin
        state_nxt = ST_BURST;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!rst_n_i) begin
      state_r <= ST_CHARGE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Start-up switch sequence and supply control.
  // ----------------------------------------------------------------
  logic charge_r;
  logic full_r;
  logic gpath_r;
  logic pd_r;
  logic inovp_r;
  logic lss_r;
  logic reg_en_r;

  always_ff @(posedge CLK) begin
    if (!rst_n_i || state_r == ST_CHARGE) begin
      charge_r <= 1'b1;
      gpath_r  <= 1'b1;
      pd_r     <= 1'b0;
      inovp_r  <= 1'b0;
      lss_r    <= 1'b0;
    end else if (state_r == ST_SEQ) begin
      case (st_tmr[2:0])
        3'h0:    charge_r <= 1'b0;
        3'h1:    gpath_r  <= 1'b0;
        3'h2:    pd_r     <= 1'b1;
        3'h3:    inovp_r  <= 1'b1;
        3'h4:    lss_r    <= 1'b1;
        default: lss_r    <= lss_r;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!rst_n_i) begin
      full_r   <= 1'b0;
      reg_en_r <= 1'b0;
    end else begin
      full_r <= s[`QFSC_S_FOLD];
      if (s[`QFSC_S_REG_ON]) begin
        reg_en_r <= 1'b1;
      end
    end
  end

  assign GATE_ON              = (state_r == ST_ON) & ~s[`QFSC_S_DSUP_OVER];
  assign CHARGE_EN            = charge_r;
  assign CHARGE_FULL_RATE     = charge_r & full_r;
  assign HV_GATE_PATH_SWITCH  = gpath_r;
  assign GATE_PULLDOWN_SWITCH = pd_r;
  assign HV_TO_INOVP_SWITCH   = inovp_r;
  assign LOWSIDE_SENSE_SWITCH = lss_r;
  assign DRIVER_SUPPLY_REG_EN = reg_en_r;
  assign LOW_QUIESCENT        = (state_r == ST_BURST);
  assign VALLEY_LOCK_EN       = vl_en_r;
  assign TRIGGER_ARMED        = armed_r;
  assign FAULT_RESTART_WAIT   = (state_r == ST_FAULT);

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n_i);

  a_fire_armed: assert property (off_st && trig_fall && !armed_r && per_cnt < force_at |=> state_r != ST_DELAY)
    else $error("unarmed trigger started a cycle");
  a_fire_delay: assert property (fire && !prio && !s[`QFSC_S_BURST_LOW] |=> state_r == ST_DELAY)
    else $error("fire did not start the turn-on delay");
  a_delay_len: assert property ($rose(state_r == ST_ON) && $past(state_r) == ST_DELAY
                                |-> $past(state_r == ST_DELAY, DLY))
    else $error("turn-on delay too short");
  a_min_period: assert property ($rose(GATE_ON) |-> $past(per_cnt) >= 16'(MINP - 1))
    else $error("switching period below limit");
  a_blank_ignore: assert property (off_st && per_cnt < blank_len |=> state_r != ST_DELAY)
    else $error("turn-on inside blanking");
  a_force_on: assert property (off_st && locked_r && per_cnt == force_at && !prio
                               && !s[`QFSC_S_BURST_LOW] |=> state_r == ST_DELAY)
    else $error("forced turn-on missing");
  a_burst_stop: assert property (run_st && s[`QFSC_S_BURST_LOW] && !prio |=> LOW_QUIESCENT)
    else $error("burst pause not entered");
  a_burst_resume: assert property (state_r == ST_BURST && s[`QFSC_S_BURST_HIGH] && !prio
                                   |=> off_st)
    else $error("burst pause not left");
  a_restart_wait: assert property ($fell(FAULT_RESTART_WAIT) && state_r == ST_DSUP_WAIT
                                   |-> $past(st_tmr) >= RSTM1)
    else $error("restart interval cut short");
  a_vl_hyst: assert property ($rose(vl_en_r) |-> $past(s[`QFSC_S_VL_ON]) && !$past(s[`QFSC_S_VL_OFF]))
    else $error("valley lock enabled without rise");
  a_seq_order: assert property ($rose(lss_r) |-> !charge_r && !gpath_r && pd_r && inovp_r)
    else $error("start-up switch order broken");
  a_dsup_wait: assert property ($fell(state_r == ST_DSUP_WAIT) && off_st |-> $past(s[`QFSC_S_DSUP_GOOD]))
    else $error("switching before driver supply good");
  a_lockout_rst: assert property (@(posedge CLK) disable iff (!RST_B)
                                  lockout_fall |=> state_r == ST_CHARGE && !armed_r)
    else $error("lockout did not reset state");

  c_trig_fire: cover property (fire_trig ##1 state_r == ST_DELAY);
  c_force: cover property (off_st && !fire_trig && fire);
  c_burst: cover property (state_r == ST_BURST ##1 off_st);
  c_fault: cover property ($fell(FAULT_RESTART_WAIT));

endmodule

// File: tb/qfsc_aux_model.sv
`timescale 1ns/1ps
module qfsc_aux_model (
  input  wire logic       CLK,
  input  wire logic       GATE_ON,
  input  wire logic [1:0] mode,
  output logic            DEMAG_ABOVE_ARM,
  output logic            DEMAG_BELOW_TRIG,
  output logic            CURRENT_LIMIT
);
  // ----------------------------------------------------------------
  // Winding model: 0 silent, 1 ringing, 2 arm level only, 3 ringing too small to arm.
  // ----------------------------------------------------------------
  logic [15:0] on_cnt_r  = 16'h0000;
  logic [15:0] off_cnt_r = 16'h0000;
  logic        ring_hi;

  always_ff @(posedge CLK) begin
    on_cnt_r  <= GATE_ON ? on_cnt_r + 16'h0001 : 16'h0000;
    off_cnt_r <= GATE_ON ? 16'h0000 : off_cnt_r + 16'h0001;
  end

  // The sense line rings with a 32-cycle period after turn-off and sits low during the on-time.
  assign ring_hi          = ~off_cnt_r[4];
  assign CURRENT_LIMIT    = GATE_ON & (on_cnt_r >= 16'h0014);
  assign DEMAG_ABOVE_ARM  = ~GATE_ON & ((mode == 2'h1) ? ring_hi : (mode == 2'h2));
  assign DEMAG_BELOW_TRIG = GATE_ON | (mode[0] ? ~ring_hi : (mode == 2'h0));
endmodule

// File: tb/qfsc_core_bench.sv
`timescale 1ns/1ps
module qfsc_core_bench;
  // ----------------------------------------------------------------
  // Stimulus, design and winding model.
  // ----------------------------------------------------------------
  localparam int RC = 200;
  logic        CLK, RST_B, DEMAG_ABOVE_ARM, DEMAG_BELOW_TRIG, CURRENT_LIMIT, GATE_ON;
  logic        FEEDBACK_BELOW_BURST_HYST, FEEDBACK_ABOVE_BURST, FEEDBACK_BELOW_VL_OFF, FEEDBACK_ABOVE_VL_ON;
  logic        SUPPLY_ABOVE_FOLDBACK, SUPPLY_ABOVE_REG_ON, SUPPLY_ABOVE_STARTUP, SUPPLY_BELOW_TURNOFF;
  logic        SUPPLY_ABOVE_LOCKOUT, DRIVER_SUPPLY_GOOD, DRIVER_SUPPLY_LOW, DRIVER_SUPPLY_OVER;
  logic        OVER_TEMP, RECT_SHORT_FAULT, CHARGE_EN, CHARGE_FULL_RATE, HV_GATE_PATH_SWITCH;
  logic        GATE_PULLDOWN_SWITCH, HV_TO_INOVP_SWITCH, LOWSIDE_SENSE_SWITCH, DRIVER_SUPPLY_REG_EN;
  logic        LOW_QUIESCENT, VALLEY_LOCK_EN, TRIGGER_ARMED, FAULT_RESTART_WAIT;
  logic [3:0]  FEEDBACK_CODE;
  logic [1:0]  mode;
  logic [11:0] outs;
  logic [4:0]  sw;
  logic [31:0] g, f, p, pv;
  logic [31:0] pf [3];
  logic [3:0]  cd [3] = '{4'hF, 4'h7, 4'h0};
  logic [4:0]  sq [5] = '{5'h08, 5'h00, 5'h04, 5'h06, 5'h07};
  int          k;
  int          n_fail = 0;
  int          samples_checked = 0;

  assign outs = {GATE_ON, CHARGE_EN, CHARGE_FULL_RATE, HV_GATE_PATH_SWITCH, GATE_PULLDOWN_SWITCH,
                 HV_TO_INOVP_SWITCH, LOWSIDE_SENSE_SWITCH, DRIVER_SUPPLY_REG_EN, LOW_QUIESCENT,
                 VALLEY_LOCK_EN, TRIGGER_ARMED, FAULT_RESTART_WAIT};
  assign sw   = {CHARGE_EN, HV_GATE_PATH_SWITCH, GATE_PULLDOWN_SWITCH, HV_TO_INOVP_SWITCH, LOWSIDE_SENSE_SWITCH};

  qfsc_core #(.RESTART_CYC(RC)) u_dut (.*);
  qfsc_aux_model u_aux (.*);

  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  initial begin
    #2000000;
    n_fail++;
    finish_test;
  end

  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------
  function automatic int blank(input logic [3:0] c);
    return 400 - (296 * c) / 15;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Counts gate pulses and restart-wait cycles over a window.
  task automatic win(input int n, output logic [31:0] gc, output logic [31:0] fc);
    logic q;
    q  = GATE_ON;
    gc = 0;
    fc = 0;
    repeat (n) begin
      @(negedge CLK);
      if (GATE_ON === 1'b1 && q !== 1'b1) gc++;
      if (FAULT_RESTART_WAIT === 1'b1) fc++;
      q = GATE_ON;
    end
  endtask

  // Cycles from one gate rise to the next; zero when none is seen.
  task automatic per(output logic [31:0] pr);
    logic q;
    int   i;
    int   t0;
    t0 = -1;
    pr = 0;
    q  = GATE_ON;
    for (i = 0; i < 3000 && pr == 0; i++) begin
      @(negedge CLK);
      if (GATE_ON === 1'b1 && q !== 1'b1) begin
        if (t0 >= 0) pr = i - t0;
        else t0 = i;
      end
      q = GATE_ON;
    end
  endtask

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    {RST_B, FEEDBACK_BELOW_BURST_HYST, FEEDBACK_ABOVE_VL_ON, SUPPLY_ABOVE_FOLDBACK, SUPPLY_ABOVE_REG_ON,
     SUPPLY_ABOVE_STARTUP, SUPPLY_BELOW_TURNOFF, DRIVER_SUPPLY_GOOD, DRIVER_SUPPLY_LOW,
     DRIVER_SUPPLY_OVER, OVER_TEMP, RECT_SHORT_FAULT} = '0;
    {SUPPLY_ABOVE_LOCKOUT, FEEDBACK_ABOVE_BURST, FEEDBACK_BELOW_VL_OFF} = 3'h7;
    FEEDBACK_CODE = 4'hF;
    mode = 2'h3;
    cyc(3);
    RST_B <= 1'b1;
    @(negedge CLK);
    chk(outs, 12'h500);
    cyc(1);
    SUPPLY_ABOVE_FOLDBACK <= 1'b1;
    SUPPLY_ABOVE_REG_ON   <= 1'b1;
    cyc(5);
    @(negedge CLK);
    chk(CHARGE_FULL_RATE, 1'b1);
    chk(DRIVER_SUPPLY_REG_EN, 1'b1);
    cyc(1);
    SUPPLY_ABOVE_STARTUP <= 1'b1;
    for (k = 0; k < 12 && CHARGE_EN !== 1'b0; k++) @(negedge CLK);
    foreach (sq[i]) begin
      chk(sw, sq[i]);
      @(negedge CLK);
    end
    win(800, g, f);
    chk(g, 0);
    cyc(1);
    DRIVER_SUPPLY_GOOD <= 1'b1;
    per(p);
    chk(p >= blank(15) + 575 && p <= blank(15) + 587, 1'b1);
    chk(TRIGGER_ARMED, 1'b0);
    cyc(1);
    DRIVER_SUPPLY_OVER <= 1'b1;
    cyc(4);
    win(1500, g, f);
    chk(g, 0);
    cyc(1);
    DRIVER_SUPPLY_OVER <= 1'b0;
    mode <= 2'h2;
    per(p);
    foreach (cd[i]) begin
      cyc(1);
      FEEDBACK_CODE <= cd[i];
      per(p);
      per(pf[i]);
    end
    chk(pf[0] >= blank(15) + 68 && pf[0] <= blank(15) + 80, 1'b1);
    for (k = 1; k < 3; k++) chk(pf[k] - pf[0], blank(cd[k]) - blank(15));
    cyc(1);
    mode <= 2'h1;
    foreach (cd[i]) begin
      cyc(1);
      FEEDBACK_CODE <= cd[i];
      per(p);
      per(p);
      chk(p >= blank(cd[i]) && p <= blank(cd[i]) + 44, 1'b1);
      chk(p >= 105, 1'b1);
    end
    cyc(1);
    FEEDBACK_BELOW_VL_OFF <= 1'b0;
    FEEDBACK_ABOVE_VL_ON  <= 1'b1;
    cyc(5);
    FEEDBACK_ABOVE_VL_ON <= 1'b0;
    per(p);
    cyc(1);
    FEEDBACK_CODE <= 4'h2;
    per(pv);
    per(pv);
    chk(VALLEY_LOCK_EN, 1'b1);
    chk(pv, p);
    cyc(1);
    FEEDBACK_BELOW_VL_OFF <= 1'b1;
    cyc(5);
    @(negedge CLK);
    chk(VALLEY_LOCK_EN, 1'b0);
    cyc(1);
    FEEDBACK_ABOVE_BURST      <= 1'b0;
    FEEDBACK_BELOW_BURST_HYST <= 1'b1;
    cyc(6);
    FEEDBACK_BELOW_BURST_HYST <= 1'b0;
    win(600, g, f);
    chk(g, 0);
    chk(LOW_QUIESCENT, 1'b1);
    cyc(1);
    FEEDBACK_ABOVE_BURST <= 1'b1;
    win(600, g, f);
    chk(g != 0, 1'b1);
    chk(LOW_QUIESCENT, 1'b0);
    cyc(1);
    {DRIVER_SUPPLY_GOOD, DRIVER_SUPPLY_LOW} <= 2'h1;
    cyc(6);
    win(600, g, f);
    chk(g, 0);
    cyc(1);
    {DRIVER_SUPPLY_GOOD, DRIVER_SUPPLY_LOW} <= 2'h2;
    for (k = 0; k < 2; k++) begin
      cyc(1);
      {OVER_TEMP, RECT_SHORT_FAULT} <= 2'h2 >> k;
      cyc(1);
      {OVER_TEMP, RECT_SHORT_FAULT} <= 2'h0;
      win(400, g, f);
      chk(f, RC);
    end
    cyc(1);
    SUPPLY_BELOW_TURNOFF <= 1'b1;
    SUPPLY_ABOVE_STARTUP <= 1'b0;
    mode                 <= 2'h0;
    cyc(5);
    @(negedge CLK);
    chk({GATE_ON, CHARGE_EN, HV_GATE_PATH_SWITCH}, 3'h3);
    cyc(1);
    {SUPPLY_ABOVE_LOCKOUT, SUPPLY_ABOVE_FOLDBACK, SUPPLY_ABOVE_REG_ON} <= 3'h0;
    cyc(5);
    @(negedge CLK);
    chk(outs, 12'h500);
    finish_test;
  end
endmodule
